/* File: rfc_apb_master.sv */
/*
 * Write-only APB master: one register write per request.
 * Assumes req is offered only while busy is low.
 */
module rfc_apb_master
    import rfc_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Request side.
    input  wire logic        req,
    input  wire logic [7:0]  req_addr,
    input  wire logic [31:0] req_wdata,
    output logic             busy,
    output logic             done,
    // APB master side.
    output logic             m_psel,
    output logic             m_penable,
    output logic             m_pwrite,
    output logic [7:0]       m_paddr,
    output logic [31:0]      m_pwdata,
    input  wire logic        m_pready
);

    assign busy = m_psel;

    // Setup, then access until pready; request held throughout.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_psel    <= 1'b0;
            m_penable <= 1'b0;
            m_pwrite  <= 1'b1;
            m_paddr   <= 8'h00;
            m_pwdata  <= 32'h0000_0000;
            done      <= 1'b0;
        end else begin
            done     <= 1'b0;
            m_pwrite <= 1'b1;
            if (m_psel && m_penable) begin
                if (m_pready) begin
                    m_psel    <= 1'b0;
                    m_penable <= 1'b0;
                    done      <= 1'b1;
                end
            end else if (m_psel) begin
                m_penable <= 1'b1;
            end else if (req) begin
                m_psel   <= 1'b1;
                m_paddr  <= req_addr;
                m_pwdata <= req_wdata;
            end
        end
    end

endmodule // rfc_apb_master

/* File: rfc_dev.sv */
/*
 * Behavioural resizer: register port and one-shot frame timing.
 * Assumes a write-only APB master on pclk.
 */
module rfc_dev
    import rfc_pkg::*;
#(
    parameter int FRAME_CYC = 40,
    parameter int DRAIN_CYC = 12
)
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Register port.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    // Events and bench controls.
    output logic             eof_irq,
    output logic             dma_evt,
    input  wire logic [1:0]  slow,
    input  wire logic        up_sof
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctrl_r;
    logic [31:0] cfg_r [RFC_CFG_NUM];
    logic [31:0] act_r [RFC_CFG_NUM];
    logic        busy_r;
    logic [15:0] cnt_r;
    logic [15:0] drain_r;
    logic [1:0]  wait_r;
    logic        wr;
    logic [7:0]  ofs;

    assign pready = psel && penable && (wait_r == slow);
    assign wr = pready && pwrite;
    assign ofs = paddr - RFC_DEV_CFG_OFS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 2'h0;
        end else if (psel && penable && !pready) begin
            wait_r <= wait_r + 2'h1;
        end else begin
            wait_r <= 2'h0;
        end
    end

    // Pointer slots always writable, locked slots only when idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= '{default: 32'h0};
        end else if (wr && paddr != RFC_DEV_CTRL_OFS && paddr <= 8'h1c) begin
            if (!busy_r || ofs[4:2] > 3'h2) begin
                cfg_r[ofs[4:2]] <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h0;
            busy_r <= 1'b0;
            cnt_r <= 16'h0;
            drain_r <= 16'h0;
            eof_irq <= 1'b0;
            dma_evt <= 1'b0;
            act_r <= '{default: 32'h0};
        end else begin
            dma_evt <= 1'b0;
            eof_irq <= 1'b0;
            if (wr && paddr == RFC_DEV_CTRL_OFS) begin
                ctrl_r <= pwdata;
            end else if (ctrl_r[RFC_CTRL_ENABLE] && !busy_r &&
                         (ctrl_r[RFC_CTRL_SOURCE] || up_sof)) begin
                ctrl_r[RFC_CTRL_ENABLE] <= 1'b0;
                busy_r <= 1'b1;
                cnt_r <= 16'(FRAME_CYC);
                act_r <= cfg_r;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 16'h1;
                if (cnt_r == 16'h1) begin
                    busy_r <= 1'b0;
                    dma_evt <= 1'b1;
                    drain_r <= 16'(DRAIN_CYC);
                end
            end
            if (drain_r != 16'h0) begin
                drain_r <= drain_r - 16'h1;
                eof_irq <= (drain_r == 16'h1);
            end
        end
    end
endmodule // rfc_dev

/* File: rfc_host.sv */
/*
 * Frame controller for an image resizer: software loads a setup and a
 * start over APB; a checked setup is written into the resizer after the
 * previous frame ends, then the resizer is enabled.
 * Assumes dev_eof_irq is synchronous to pclk and the resizer answers APB.
 */
// Functional notes
// - Set up between frames, then enable.
// - Hold locked changes until resize ends.
// - Ratios within 64 to 1024.
// - Width under 1280, 640 above ratio 512.
// - Width even; upsizing needs 16-byte multiple.
// - Upstream feed: zero input pointers, interleaved.
// - Memory feed: start pixel limits.
// - Output address and offset 32-byte aligned.
// - Over 1280 wide: memory slices only.
// - Over 4x either way: several passes.
// - Next pass starts on end of frame.
module rfc_host
    import rfc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Software APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // Resizer register port.
    output logic                   dev_psel,
    output logic                   dev_penable,
    output logic                   dev_pwrite,
    output logic [7:0]             dev_paddr,
    output logic [31:0]            dev_pwdata,
    input  wire logic              dev_pready,
    // Resizer events.
    input  wire logic              dev_eof_irq,
    // Controller state.
    output logic                   frame_open
);

    if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
        $error("rfc_host: ADDR_W must lie in 8 to 16");
    end

    typedef enum logic [4:0] {
        RFC_S_IDLE  = 5'b00001,
        RFC_S_WAIT  = 5'b00010,
        RFC_S_ISSUE = 5'b00100,
        RFC_S_XFER  = 5'b01000,
        RFC_S_NEXT  = 5'b10000
    } rfc_state_e;

    rfc_state_e  state_r;
    logic [31:0] cfg_r [RFC_CFG_NUM];
    logic        source_mem_r;
    logic        done_r;
    logic        reject_r;
    logic        eof_d_r;
    logic [2:0]  idx_r;
    logic        pass_mem_r;

    logic        m_req;
    logic [7:0]  m_addr;
    logic [31:0] m_wdata;
    logic        m_busy;
    logic        m_done;

    // Software access decode.
    logic       setup_ph;
    logic       wr_fire;
    logic [7:0] ofs;
    logic       ofs_cfg;
    logic [2:0] ofs_idx;
    logic       ofs_hit;
    logic [7:0] ofs_rel;

    assign setup_ph = psel && !penable;
    assign wr_fire  = psel && penable && pwrite && pready && !pslverr;
    assign ofs      = paddr[7:0];
    assign ofs_rel  = ofs - RFC_CFG_OFS;
    assign ofs_cfg  = ofs >= RFC_CFG_OFS
                      && ofs_rel[7:2] < 6'(RFC_CFG_NUM)
                      && ofs[1:0] == 2'b00;
    assign ofs_idx  = ofs_rel[4:2];
    assign ofs_hit  = ofs_cfg || ofs == RFC_CMD_OFS
                      || ofs == RFC_STATUS_OFS || ofs == RFC_SOURCE_OFS;

    // Fields for the frame checks.
    logic [10:0] hratio;
    logic [10:0] vratio;
    logic        fmt_sep;
    logic [12:0] out_width;
    logic [4:0]  hstart;
    logic [4:0]  vstart;
    logic        cfg_ok;
    logic        ratio_ok;
    logic        width_ok;
    logic        feed_ok;
    logic        align_ok;

    assign hratio    = cfg_r[RFC_CFG_RESIZE][RFC_HRATIO_LSB +: RFC_RATIO_W];
    assign vratio    = cfg_r[RFC_CFG_RESIZE][RFC_VRATIO_LSB +: RFC_RATIO_W];
    assign fmt_sep   = cfg_r[RFC_CFG_RESIZE][RFC_FORMAT_BIT];
    assign out_width = cfg_r[RFC_CFG_OUT_SIZE][RFC_WIDTH_LSB +: RFC_SIZE_W];
    assign hstart    = cfg_r[RFC_CFG_IN_START][RFC_HSTART_LSB +: RFC_START_W];
    assign vstart    = cfg_r[RFC_CFG_IN_START][RFC_VSTART_LSB +: RFC_START_W];

    // Ratio range also keeps each pass within 4x either way.
    assign ratio_ok = hratio >= RFC_RATIO_MIN && hratio <= RFC_RATIO_MAX
                      && vratio >= RFC_RATIO_MIN
                      && vratio <= RFC_RATIO_MAX;

    // Width limits.
    always_comb begin
        width_ok = !out_width[0];
        if (vratio <= RFC_RATIO_MID) begin
            width_ok = width_ok && out_width < RFC_WIDE_LIMIT;
        end else begin
            width_ok = width_ok && out_width < RFC_NARROW_LIM;
        end
        if (vratio < RFC_RATIO_UNITY) begin
            width_ok = width_ok
                       && out_width[RFC_ALIGN_UP-1:0] == '0;
        end
    end

    // Source dependent limits.
    always_comb begin
        if (source_mem_r) begin
            feed_ok = vstart == '0
                      && hstart <= (fmt_sep ? RFC_HSTART_SEP
                                            : RFC_HSTART_IL);
        end else begin
            feed_ok = !fmt_sep && cfg_r[RFC_CFG_IN_ADDR] == '0
                      && cfg_r[RFC_CFG_IN_OFF] == '0;
        end
    end

    assign align_ok = cfg_r[RFC_CFG_OUT_ADDR][RFC_ALIGN_OUT-1:0] == '0
                      && cfg_r[RFC_CFG_OUT_OFF][RFC_ALIGN_OUT-1:0]
                         == '0;
    assign cfg_ok   = ratio_ok && width_ok && feed_ok && align_ok;

    // Start command and end-of-frame edge.
    logic start_cmd;
    logic eof_rise;
    logic cfg_lock;

    assign start_cmd = wr_fire && ofs == RFC_CMD_OFS
                       && pwdata[RFC_CMD_START];
    assign eof_rise  = dev_eof_irq && !eof_d_r;
    assign cfg_lock  = state_r != RFC_S_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eof_d_r <= 1'b0;
        end else begin
            eof_d_r <= dev_eof_irq;
        end
    end

    // Setup words, frozen from an accepted start until written.
    for (genvar i = 0; i < RFC_CFG_NUM; i++) begin : g_cfg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_r[i] <= 32'h0000_0000;
            end else if (wr_fire && ofs_cfg && ofs_idx == 3'(i)
                         && !cfg_lock) begin
                cfg_r[i] <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_mem_r <= 1'b0;
        end else if (wr_fire && ofs == RFC_SOURCE_OFS && !cfg_lock) begin
            source_mem_r <= pwdata[RFC_SRC_MEMORY];
        end
    end

    // Sequencer: wait for the previous frame, write setup, then enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= RFC_S_IDLE;
            idx_r      <= 3'h0;
            pass_mem_r <= 1'b0;
        end else begin
            unique case (state_r)
                RFC_S_IDLE: begin
                    if (start_cmd && cfg_ok) begin
                        idx_r      <= 3'h0;
                        pass_mem_r <= source_mem_r;
                        state_r    <= RFC_S_WAIT;
                    end
                end
                RFC_S_WAIT: begin
                    if (!frame_open || eof_rise) begin
                        state_r <= RFC_S_ISSUE;
                    end
                end
                RFC_S_ISSUE: begin
                    state_r <= RFC_S_XFER;
                end
                RFC_S_XFER: begin
                    if (m_done) begin
                        state_r <= RFC_S_NEXT;
                    end
                end
                RFC_S_NEXT: begin
                    if (idx_r == 3'(RFC_CFG_NUM)) begin
                        state_r <= RFC_S_IDLE;
                    end else begin
                        idx_r   <= idx_r + 3'h1;
                        state_r <= RFC_S_ISSUE;
                    end
                end
            endcase
        end
    end

    // Setup words first, enable word last.
    always_comb begin
        m_req   = state_r == RFC_S_ISSUE && !m_busy;
        m_addr  = RFC_DEV_CTRL_OFS;
        m_wdata = 32'h0000_0000;
        if (idx_r < 3'(RFC_CFG_NUM)) begin
            m_addr  = RFC_DEV_CFG_OFS + {3'h0, idx_r, 2'b00};
            m_wdata = cfg_r[idx_r];
        end else begin
            m_wdata[RFC_CTRL_ENABLE] = 1'b1;
            m_wdata[RFC_CTRL_SOURCE] = pass_mem_r;
        end
    end

    rfc_apb_master u_master (
        .pclk      (pclk),
        .presetn   (presetn),
        .req       (m_req),
        .req_addr  (m_addr),
        .req_wdata (m_wdata),
        .busy      (m_busy),
        .done      (m_done),
        .m_psel    (dev_psel),
        .m_penable (dev_penable),
        .m_pwrite  (dev_pwrite),
        .m_paddr   (dev_paddr),
        .m_pwdata  (dev_pwdata),
        .m_pready  (dev_pready)
    );

    // Open from enable write to end of frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_open <= 1'b0;
        end else if (state_r == RFC_S_NEXT
                     && idx_r == 3'(RFC_CFG_NUM)) begin
            frame_open <= 1'b1;
        end else if (eof_rise) begin
            frame_open <= 1'b0;
        end
    end

    // Sticky status; set wins over clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (eof_rise) begin
            done_r <= 1'b1;
        end else if (wr_fire && ofs == RFC_STATUS_OFS
                     && pwdata[RFC_ST_DONE]) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_r <= 1'b0;
        end else if (start_cmd && state_r == RFC_S_IDLE && !cfg_ok) begin
            reject_r <= 1'b1;
        end else if (wr_fire && ofs == RFC_STATUS_OFS
                     && pwdata[RFC_ST_REJECT]) begin
            reject_r <= 1'b0;
        end
    end

    // Answer captured in the setup cycle.
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (ofs_cfg) begin
            rd_val = cfg_r[ofs_idx];
        end else if (ofs == RFC_STATUS_OFS) begin
            rd_val[RFC_ST_ACTIVE] = state_r != RFC_S_IDLE;
            rd_val[RFC_ST_OPEN]   = frame_open;
            rd_val[RFC_ST_DONE]   = done_r;
            rd_val[RFC_ST_REJECT] = reject_r;
        end else if (ofs == RFC_SOURCE_OFS) begin
            rd_val[RFC_SRC_MEMORY] = source_mem_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && (!ofs_hit || (paddr >> 8) != '0);
            if (setup_ph && !pwrite) begin
                prdata <= rd_val;
            end
        end
    end

endmodule // rfc_host

/* File: rfc_host_asserts.sv */
/*
 * Port checker for the resizer frame controller.
 * Assumes it is bound to rfc_host and sees only its ports.
 */
module rfc_host_asserts
    import rfc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    input wire logic              dev_psel,
    input wire logic              dev_penable,
    input wire logic              dev_pwrite,
    input wire logic [7:0]        dev_paddr,
    input wire logic [31:0]       dev_pwdata,
    input wire logic              dev_pready,
    input wire logic              dev_eof_irq,
    input wire logic              frame_open
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_next;
        psel && !penable |=> pready
            && pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0);
    endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("late or wrong answer");
    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready too long");
    property p_dev_setup;
        dev_psel && !dev_penable |=> dev_psel && dev_penable
            && $stable(dev_paddr);
    endproperty
    a_dev_setup: assert property (p_dev_setup)
        else $error("no access phase");
    property p_dev_hold;
        dev_psel && dev_penable && !dev_pready |=> dev_psel && dev_penable
            && $stable(dev_paddr) && $stable(dev_pwdata);
    endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("request not held");
    property p_dev_map;
        dev_psel |-> dev_pwrite && dev_paddr[1:0] == 2'h0
            && dev_paddr <= 8'h1c;
    endproperty
    a_dev_map: assert property (p_dev_map)
        else $error("bad resizer access");
    property p_enable_word;
        dev_psel && dev_paddr == RFC_DEV_CTRL_OFS
            |-> dev_pwdata[RFC_CTRL_ENABLE];
    endproperty
    a_enable_word: assert property (p_enable_word)
        else $error("no enable bit");
    property p_locked_hold;
        frame_open |-> !dev_psel;
    endproperty
    a_locked_hold: assert property (p_locked_hold)
        else $error("write in open frame");
    property p_eof_close;
        $rose(dev_eof_irq) && frame_open |-> ##[1:2] !frame_open;
    endproperty
    a_eof_close: assert property (p_eof_close)
        else $error("frame not closed");
    property p_dev_gap;
        $fell(dev_psel) |-> !dev_psel ##1 !dev_psel;
    endproperty
    a_dev_gap: assert property (p_dev_gap)
        else $error("writes too close");

    c_open: cover property ($rose(frame_open));
    c_err: cover property (pslverr);
    c_wait: cover property (dev_psel && dev_penable && !dev_pready);
    c_eof: cover property ($rose(dev_eof_irq) && frame_open);
endmodule // rfc_host_asserts

bind rfc_host rfc_host_asserts #(.ADDR_W(ADDR_W)) i_rfc_host_asserts (.*);

/* File: rfc_pkg.sv */
/*
 * Shared constants of the resizer frame controller: both register maps,
 * field layout and programming limits.
 * Assumes a 32-bit APB on both sides and byte addresses.
 */
package rfc_pkg;

    // Controller register map.
    localparam logic [7:0] RFC_CMD_OFS    = 8'h00;
    localparam logic [7:0] RFC_STATUS_OFS = 8'h04;
    localparam logic [7:0] RFC_SOURCE_OFS = 8'h08;
    localparam logic [7:0] RFC_CFG_OFS    = 8'h0c;
    localparam int         RFC_CFG_NUM    = 7;

    // Controller command and status bits.
    localparam int RFC_CMD_START  = 0;
    localparam int RFC_ST_ACTIVE  = 0;
    localparam int RFC_ST_OPEN    = 1;
    localparam int RFC_ST_DONE    = 2;
    localparam int RFC_ST_REJECT  = 3;
    localparam int RFC_SRC_MEMORY = 0;

    // Configuration slots in write order.
    localparam int RFC_CFG_RESIZE   = 0;
    localparam int RFC_CFG_OUT_SIZE = 1;
    localparam int RFC_CFG_IN_START = 2;
    localparam int RFC_CFG_IN_ADDR  = 3;
    localparam int RFC_CFG_IN_OFF   = 4;
    localparam int RFC_CFG_OUT_ADDR = 5;
    localparam int RFC_CFG_OUT_OFF  = 6;

    // Resizer register map.
    localparam logic [7:0] RFC_DEV_CTRL_OFS = 8'h00;
    localparam logic [7:0] RFC_DEV_CFG_OFS  = 8'h04;

    // Field layout of engine_control_reg.
    localparam int RFC_CTRL_ENABLE = 0;
    localparam int RFC_CTRL_SOURCE = 2;

    // Field layout of resize_control.
    localparam int RFC_HRATIO_LSB = 0;
    localparam int RFC_VRATIO_LSB = 16;
    localparam int RFC_RATIO_W    = 11;
    localparam int RFC_FORMAT_BIT = 28;

    // Field layout of the size and start words.
    localparam int RFC_WIDTH_LSB  = 0;
    localparam int RFC_SIZE_W     = 13;
    localparam int RFC_HEIGHT_LSB = 16;
    localparam int RFC_HSTART_LSB = 0;
    localparam int RFC_VSTART_LSB = 16;
    localparam int RFC_START_W    = 5;

    // Programming limits.
    localparam logic [10:0] RFC_RATIO_MIN   = 11'h040;
    localparam logic [10:0] RFC_RATIO_MAX   = 11'h400;
    localparam logic [10:0] RFC_RATIO_UNITY = 11'h100;
    localparam logic [10:0] RFC_RATIO_MID   = 11'h200;
    localparam logic [12:0] RFC_WIDE_LIMIT  = 13'h0500;
    localparam logic [12:0] RFC_NARROW_LIM  = 13'h0280;
    localparam logic [4:0]  RFC_HSTART_IL   = 5'h0f;
    localparam logic [4:0]  RFC_HSTART_SEP  = 5'h1f;
    localparam int          RFC_ALIGN_OUT   = 5;
    localparam int          RFC_ALIGN_UP    = 4;

endpackage

/* File: tb_resizer_frame_control.sv */
/*
 * Bench for the resizer frame controller with a resizer model.
 * Assumes the model stands on the controller's resizer port.
 */
module tb_resizer_frame_control
    import rfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] RS_GOOD = 32'h0100_0100;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        dev_psel, dev_penable, dev_pwrite, dev_pready;
    logic        dev_eof_irq, frame_open, up_sof, rerr;
    logic [7:0]  paddr, dev_paddr;
    logic [31:0] pwdata, prdata, dev_pwdata, rdata;
    logic [1:0]  slow;
    logic [31:0] good_cfg [RFC_CFG_NUM];
    logic [31:0] exp_cfg [RFC_CFG_NUM];
    int          n_errors = 0, num_checks = 0, n_dev = 0, cycles = 0;

    rfc_host #(.ADDR_W(8)) i_rfc_host (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .dev_psel(dev_psel),
        .dev_penable(dev_penable), .dev_pwrite(dev_pwrite),
        .dev_paddr(dev_paddr), .dev_pwdata(dev_pwdata),
        .dev_pready(dev_pready), .dev_eof_irq(dev_eof_irq),
        .frame_open(frame_open)
    );
    rfc_dev i_rfc_dev (
        .pclk(pclk), .presetn(presetn), .psel(dev_psel),
        .penable(dev_penable), .pwrite(dev_pwrite), .paddr(dev_paddr),
        .pwdata(dev_pwdata), .pready(dev_pready), .eof_irq(dev_eof_irq),
        .dma_evt(), .slow(slow), .up_sof(up_sof)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        n_dev += int'(dev_psel && dev_penable && dev_pready);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic load(input logic src, input logic [31:0] rs);
        apb(1'b1, RFC_SOURCE_OFS, {31'h0, src});
        for (int i = 0; i < RFC_CFG_NUM; i++) begin
            exp_cfg[i] = (i == 0) ? rs : good_cfg[i];
            if (!src && (i == RFC_CFG_IN_ADDR || i == RFC_CFG_IN_OFF)) begin
                exp_cfg[i] = 32'h0;
            end
            apb(1'b1, RFC_CFG_OFS + 8'(4 * i), exp_cfg[i]);
        end
    endtask

    task automatic t_reset();
        apb(1'b0, RFC_STATUS_OFS, 32'h0);
        chk("status reset", rdata, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", rerr, 32'h1);
        chk("unmapped data", rdata, 32'h0);
        apb(1'b1, RFC_CFG_OFS, 32'h0);
        chk("mapped err", rerr, 32'h0);
    endtask

    task automatic t_frame(input logic [1:0] s, input logic [31:0] rs,
                           input logic src);
        int base;
        slow <= s;
        load(src, rs);
        base = n_dev;
        apb(1'b1, RFC_CMD_OFS, 32'h1);
        while (n_dev != base + 8) @(posedge pclk);
        if (!src) begin
            repeat (20) @(posedge pclk);
            chk("upstream wait", i_rfc_dev.busy_r, 32'h0);
            up_sof <= 1'b1;
            @(posedge pclk);
            up_sof <= 1'b0;
        end
        while (frame_open !== 1'b1) @(posedge pclk);
        apb(1'b0, RFC_STATUS_OFS, 32'h0);
        chk("open bit", rdata[RFC_ST_OPEN], 32'h1);
        while (i_rfc_dev.busy_r !== 1'b1) @(posedge pclk);
        for (int i = 0; i < RFC_CFG_NUM; i++) begin
            chk("applied cfg", i_rfc_dev.act_r[i], exp_cfg[i]);
        end
        chk("ctrl word", i_rfc_dev.ctrl_r, {29'h0, src, 2'h0});
        while (frame_open !== 1'b0) @(posedge pclk);
        apb(1'b0, RFC_STATUS_OFS, 32'h0);
        chk("done bit", rdata[RFC_ST_DONE], 32'h1);
        apb(1'b1, RFC_STATUS_OFS, 32'h4);
        apb(1'b0, RFC_STATUS_OFS, 32'h0);
        chk("done clear", rdata[RFC_ST_DONE], 32'h0);
    endtask

    task automatic t_b2b();
        int base;
        slow <= 2'h1;
        load(1'b1, RS_GOOD);
        apb(1'b1, RFC_CMD_OFS, 32'h1);
        while (frame_open !== 1'b1) @(posedge pclk);
        apb(1'b1, RFC_CFG_OFS + 8'h14, 32'h3000);
        apb(1'b1, RFC_CMD_OFS, 32'h1);
        base = n_dev;
        while (frame_open !== 1'b0) @(posedge pclk);
        chk("writes held", n_dev, base);
        while (frame_open !== 1'b1) @(posedge pclk);
        chk("next out addr", i_rfc_dev.cfg_r[5], 32'h3000);
        while (frame_open !== 1'b0) @(posedge pclk);
    endtask

    task automatic t_reject(input logic [31:0] rs, input int slot,
                            input logic [31:0] val, input logic src);
        int base;
        load(src, rs);
        apb(1'b1, RFC_CFG_OFS + 8'(4 * slot), val);
        base = n_dev;
        apb(1'b1, RFC_CMD_OFS, 32'h1);
        rdata = 32'h0;
        for (int n = 0; n < 20 && rdata[RFC_ST_REJECT] !== 1'b1; n++) begin
            apb(1'b0, RFC_STATUS_OFS, 32'h0);
        end
        chk("reject bit", rdata[RFC_ST_REJECT], 32'h1);
        chk("no resizer write", n_dev, base);
        apb(1'b1, RFC_STATUS_OFS, 32'h8);
        apb(1'b0, RFC_STATUS_OFS, 32'h0);
        chk("reject clear", rdata[RFC_ST_REJECT], 32'h0);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, up_sof} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow = 2'h0;
        good_cfg = '{RS_GOOD, 32'h01e0_0278, 32'h0, 32'h1000, 32'h0500,
                     32'h2000, 32'h0500};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_frame(2'h0, RS_GOOD, 1'b1);
        t_frame(2'h3, 32'h0400_0040, 1'b1);
        t_frame(2'h1, RS_GOOD, 1'b0);
        t_b2b();
        t_reject(RS_GOOD, 0, 32'h0100_003f, 1'b1);
        t_reject(RS_GOOD, 0, 32'h0100_0401, 1'b1);
        t_reject(32'h0201_0100, 1, 32'h01e0_0280, 1'b1);
        t_reject(RS_GOOD, 1, 32'h01e0_0500, 1'b1);
        t_reject(RS_GOOD, 1, 32'h01e0_0279, 1'b1);
        t_reject(32'h00ff_0100, 1, 32'h01e0_0278, 1'b1);
        t_reject(RS_GOOD, 2, 32'h0000_0010, 1'b1);
        t_reject(RS_GOOD, 2, 32'h0001_0000, 1'b1);
        t_reject(RS_GOOD, 5, 32'h0000_2010, 1'b1);
        t_reject(RS_GOOD, 6, 32'h0000_0510, 1'b1);
        t_reject(RS_GOOD, 3, 32'h0000_1000, 1'b0);
        t_reject(RS_GOOD, 0, 32'h1100_0100, 1'b0);
        test_done();
    end
endmodule // tb_resizer_frame_control
